// ===== verilog/dcf_pkg.sv
// Shared constants and carrier types for the dual-clock FIFO flag block.
// Assumes a 10 MHz system clock that samples both link clocks as plain pins.
package dcf_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int          DATA_W      = 18;
  localparam int          PTR_W       = 15;
  localparam int          CNT_W       = 16;
  localparam int          OFS_W       = 15;
  localparam logic [15:0] DEPTH       = 16'h8000;
  localparam logic [15:0] HALF_DEPTH  = 16'h4000;
  localparam logic [14:0] OFS_SERIAL_DEF   = 15'h03FF;
  localparam logic [14:0] OFS_PARALLEL_DEF = 15'h007F;
  localparam logic [1:0]  FALL_EDGES  = 2'h3;
  localparam logic [1:0]  STRAP_DELAY = 2'h2;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_EMPTY_OFS = 8'h04;
  localparam logic [7:0] ADDR_FULL_OFS  = 8'h08;
  localparam logic [7:0] ADDR_LEVEL     = 8'h0C;

  typedef enum logic { DCF_STANDARD, DCF_FALL_THROUGH } dcf_mode_e;

  // Pin levels of the five status outputs.
  typedef struct packed {
    logic full;
    logic almost_full;
    logic half_full;
    logic almost_empty;
    logic empty;
  } dcf_flags_s;

  // Everything that arrives from outside the system clock domain.
  typedef struct packed {
    logic              wclk;
    logic              wen_n;
    logic [DATA_W-1:0] data;
    logic              rclk;
    logic              ren_n;
    logic              mode_si;
    logic              offset_load;
  } dcf_pins_s;

endpackage

// ===== verilog/dcf_fifo.sv
// Dual-clock 32,768 x 18 FIFO with standard and fall-through timing and flag logic.
// Assumes write and read clocks are slow pins sampled by CLK_I, and an APB master on CLK_I.
//
// What this block does
// - Mode latched from mode pin at reset
// - Standard mode: every word needs read enable
// - Fall-through: first word after three read edges
// - Write enable low stores data on write edge
// - Standard empty flag rises on write, falls empty
// - Standard almost-empty high from n+1 words
// - Standard half-full low from 16,385 words
// - Standard almost-full low from 32,768-m words
// - Standard full low at 32,768, blocks writes
// - First read from full releases full indication
// - Read enable ignored while buffer empty
// - Standard empty/full flags pass two stages
// - Output-ready low with data, high when drained
// - Fall-through almost-empty high from n+2 words
// - Fall-through half-full low from 16,386 words
// - Fall-through almost-full low from 32,769-m words
// - Input-ready high at 32,769 words, blocks writes
// - Output-ready three stages, input-ready two stages
// - Serial load strap presets offsets to 3FF
// - Parallel load strap presets offsets to 07F
// - Offsets read back only over parallel path
// - Offsets reprogrammable any time after strap capture
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo
  import dcf_pkg::*;
(
  input  wire logic              CLK_I,           // System clock, 10 MHz.
  input  wire logic              RST_I,           // Master reset, async, high.
  input  wire logic              PSEL_I,          // APB select.
  input  wire logic              PENABLE_I,       // APB enable.
  input  wire logic              PWRITE_I,        // APB direction.
  input  wire logic [ADDR_W-1:0] PADDR_I,         // APB byte address.
  input  wire logic [31:0]       PWDATA_I,        // APB write data.
  output logic      [31:0]       PRDATA_O,        // APB read data.
  output logic                   PREADY_O,        // APB ready.
  output logic                   PSLVERR_O,       // APB error, unmapped address.
  input  wire logic              WCLK_I,          // Write link clock.
  input  wire logic              WEN_N_I,         // Write enable, low active.
  input  wire logic [DATA_W-1:0] DATA_IN_BUS_I,   // Write data.
  input  wire logic              RCLK_I,          // Read link clock.
  input  wire logic              REN_N_I,         // Read enable, low active.
  input  wire logic              MODE_SI_I,       // Timing mode strap.
  input  wire logic              OFFSET_LOAD_I,   // Offset loading method strap.
  output logic      [DATA_W-1:0] DATA_OUT_O,      // Read data.
  output logic                   EMPTY_FLAG_O,    // Empty flag or output-ready.
  output logic                   FULL_FLAG_O,     // Full flag or input-ready.
  output logic                   HALF_FULL_FLAG_O,       // Half-full, low active.
  output logic                   ALMOST_EMPTY_FLAG_O,    // Almost-empty, low active.
  output logic                   ALMOST_FULL_FLAG_O      // Almost-full, low active.
);

  function automatic logic above(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    above = (a > b);
  endfunction

  // ****************************************************************
  // Pin synchronisers and link clock edges
  // ****************************************************************
  dcf_pins_s pins_raw;
  dcf_pins_s sync1_reg;
  dcf_pins_s sync2_reg;
  logic      wclk_prev_reg;
  logic      rclk_prev_reg;

  assign pins_raw = '{wclk: WCLK_I, wen_n: WEN_N_I, data: DATA_IN_BUS_I, rclk: RCLK_I,
                      ren_n: REN_N_I, mode_si: MODE_SI_I, offset_load: OFFSET_LOAD_I};

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_reg     <= '{default: 1'b0, wen_n: 1'b1, ren_n: 1'b1};
      sync2_reg     <= '{default: 1'b0, wen_n: 1'b1, ren_n: 1'b1};
      wclk_prev_reg <= 1'b0;
      rclk_prev_reg <= 1'b0;
    end else begin
      sync1_reg     <= pins_raw;
      sync2_reg     <= sync1_reg;
      wclk_prev_reg <= sync2_reg.wclk;
      rclk_prev_reg <= sync2_reg.rclk;
    end
  end

  wire logic w_edge = sync2_reg.wclk & ~wclk_prev_reg;
  wire logic r_edge = sync2_reg.rclk & ~rclk_prev_reg;

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // The straps are caught on the third edge after release so the synchronisers
  // hold the real pin levels rather than their reset value.
  dcf_mode_e        mode_reg;
  logic             serial_load_reg;
  logic             strap_done_reg;
  logic [1:0]       strap_cnt_reg;
  logic [OFS_W-1:0] empty_ofs_reg;
  logic [OFS_W-1:0] full_ofs_reg;

  wire logic             strap_take = ~strap_done_reg & (strap_cnt_reg == STRAP_DELAY);
  wire logic [OFS_W-1:0] ofs_default = sync2_reg.offset_load ? OFS_SERIAL_DEF : OFS_PARALLEL_DEF;
  wire logic             fwft = (mode_reg == DCF_FALL_THROUGH);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  wire logic apb_access = PSEL_I & PENABLE_I;
  wire logic apb_first  = apb_access & ~pready_reg;
  wire logic apb_commit = apb_access & pready_reg & PWRITE_I;
  wire logic sel_status = (PADDR_I == ADDR_STATUS);
  wire logic sel_eofs   = (PADDR_I == ADDR_EMPTY_OFS);
  wire logic sel_fofs   = (PADDR_I == ADDR_FULL_OFS);
  wire logic sel_level  = (PADDR_I == ADDR_LEVEL);
  wire logic apb_mapped = sel_status | sel_eofs | sel_fofs | sel_level;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strap_cnt_reg   <= 2'h0;
      strap_done_reg  <= 1'b0;
      mode_reg        <= DCF_STANDARD;
      serial_load_reg <= 1'b0;
      empty_ofs_reg   <= OFS_PARALLEL_DEF;
      full_ofs_reg    <= OFS_PARALLEL_DEF;
    end else if (strap_take) begin
      strap_done_reg  <= 1'b1;
      mode_reg        <= sync2_reg.mode_si ? DCF_FALL_THROUGH : DCF_STANDARD;
      serial_load_reg <= sync2_reg.offset_load;
      empty_ofs_reg   <= ofs_default;
      full_ofs_reg    <= ofs_default;
    end else begin
      if (!strap_done_reg) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (apb_commit && sel_eofs) begin
        empty_ofs_reg <= PWDATA_I[OFS_W-1:0];
      end
      if (apb_commit && sel_fofs) begin
        full_ofs_reg <= PWDATA_I[OFS_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Storage, pointers and fall-through output register
  // ****************************************************************
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0]  wptr_reg;
  logic [PTR_W-1:0]  rptr_reg;
  logic [CNT_W-1:0]  count_reg;
  logic              out_valid_reg;
  logic [1:0]        fall_cnt_reg;
  logic [DATA_W-1:0] dout_reg;

  wire logic [CNT_W-1:0] bias     = {15'h0000, fwft};
  wire logic [CNT_W-1:0] total    = count_reg + {15'h0000, out_valid_reg};
  wire logic [CNT_W-1:0] capacity = DEPTH + bias;
  wire logic             mem_some = (count_reg != 16'h0000);

  // Writes are refused when the whole capacity is used, and also when the
  // array alone is full while the fall-through register is still waiting.
  wire logic wr_ok  = w_edge & ~sync2_reg.wen_n & strap_done_reg
                    & (total != capacity) & (count_reg != DEPTH);
  wire logic rd_std = ~fwft & r_edge & ~sync2_reg.ren_n & mem_some;
  wire logic rd_ft  = fwft & r_edge & ~sync2_reg.ren_n & out_valid_reg;
  wire logic fall_due = fwft & ~out_valid_reg & mem_some & r_edge
                      & (fall_cnt_reg == FALL_EDGES - 2'h1);
  wire logic load_ft = fwft & mem_some & (rd_ft | fall_due);
  wire logic pop     = rd_std | load_ft;

  always_ff @(posedge CLK_I) begin
    if (wr_ok) begin
      mem[wptr_reg] <= sync2_reg.data;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
    end else begin
      wptr_reg      <= wptr_reg + PTR_W'(wr_ok);
      rptr_reg      <= rptr_reg + PTR_W'(pop);
      count_reg     <= count_reg + CNT_W'(wr_ok) - CNT_W'(pop);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dout_reg      <= '0;
      out_valid_reg <= 1'b0;
      fall_cnt_reg  <= 2'h0;
    end else begin
      if (pop) begin
        dout_reg <= mem[rptr_reg];
      end
      if (load_ft) begin
        out_valid_reg <= 1'b1;
      end else if (rd_ft) begin
        out_valid_reg <= 1'b0;
      end
      if (out_valid_reg || !mem_some || load_ft) begin
        fall_cnt_reg <= 2'h0;
      end else if (fwft && r_edge) begin
        fall_cnt_reg <= fall_cnt_reg + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Standard: empty high when words stored, full low at capacity.
  // Fall-through: output-ready low while the output register is valid,
  // input-ready high at capacity.
  wire logic full_raw  = fwft ? (total == capacity) : (total != capacity);
  wire logic empty_raw = fwft ? ~out_valid_reg : mem_some;
  wire logic ae_raw    = above(total, {1'b0, empty_ofs_reg} + bias);
  wire logic af_raw    = ~above(total, capacity - {1'b0, full_ofs_reg} - 16'h0001);
  wire logic hf_raw    = ~above(total, HALF_DEPTH + bias);

  logic [1:0] empty_pipe_reg;
  logic       full_pipe_reg;
  dcf_flags_s flags_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      empty_pipe_reg <= 2'b00;
      full_pipe_reg  <= 1'b1;
      flags_reg      <= '{full: 1'b1, almost_full: 1'b1, half_full: 1'b1, almost_empty: 1'b0, empty: 1'b0};
    end else if (strap_take) begin
      empty_pipe_reg    <= {2{sync2_reg.mode_si}};
      full_pipe_reg     <= ~sync2_reg.mode_si;
      flags_reg.empty   <= sync2_reg.mode_si;
      flags_reg.full    <= ~sync2_reg.mode_si;
    end else begin
      flags_reg.half_full <= hf_raw;
      if (r_edge) begin
        empty_pipe_reg         <= {empty_pipe_reg[0], empty_raw};
        flags_reg.empty        <= fwft ? empty_pipe_reg[1] : empty_pipe_reg[0];
        flags_reg.almost_empty <= ae_raw;
      end
      if (w_edge) begin
        full_pipe_reg         <= full_raw;
        flags_reg.full        <= full_pipe_reg;
        flags_reg.almost_full <= af_raw;
      end
    end
  end

  // ****************************************************************
  // Register read path
  // ****************************************************************
  // Offsets read back here only; there is no serial readback path.
  wire logic [31:0] rd_mux =
      sel_status ? {24'h000000, strap_done_reg, serial_load_reg, fwft, flags_reg} :
      sel_eofs   ? {17'h00000, empty_ofs_reg} :
      sel_fofs   ? {17'h00000, full_ofs_reg} :
      sel_level  ? {16'h0000, total} : 32'h00000000;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_first;
      pslverr_reg <= apb_first & ~apb_mapped;
      if (apb_first && !PWRITE_I) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign PRDATA_O            = prdata_reg;
  assign PREADY_O            = pready_reg;
  assign PSLVERR_O           = pslverr_reg;
  assign DATA_OUT_O          = dout_reg;
  assign EMPTY_FLAG_O        = flags_reg.empty;
  assign FULL_FLAG_O         = flags_reg.full;
  assign HALF_FULL_FLAG_O    = flags_reg.half_full;
  assign ALMOST_EMPTY_FLAG_O = flags_reg.almost_empty;
  assign ALMOST_FULL_FLAG_O  = flags_reg.almost_full;

  // ****************************************************************
  // Checker history
  // ****************************************************************
  // Raw empty and full levels at the last link edges. The strap load copies
  // the empty-buffer level of each mode, so the first link edge is checked too.
  logic [1:0] chk_empty_hist_reg;
  logic       chk_full_hist_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      chk_empty_hist_reg <= 2'b00;
      chk_full_hist_reg  <= 1'b1;
    end else if (strap_take) begin
      chk_empty_hist_reg <= {2{sync2_reg.mode_si}};
      chk_full_hist_reg  <= ~sync2_reg.mode_si;
    end else begin
      if (r_edge) begin
        chk_empty_hist_reg <= {chk_empty_hist_reg[0], empty_raw};
      end
      if (w_edge) begin
        chk_full_hist_reg <= full_raw;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_read_step;
    strap_done_reg && r_edge;
  endsequence

  sequence s_write_step;
    strap_done_reg && w_edge;
  endsequence

  sequence s_fall_ready;
    fwft && !out_valid_reg && mem_some && r_edge && fall_cnt_reg == 2'h2;
  endsequence

  chk_fall_through_three: assert property (s_fall_ready |=> out_valid_reg && !$past(out_valid_reg))
    else $error("fall-through word not loaded on third read edge");
  chk_fall_needs_edges: assert property ($rose(out_valid_reg) |-> $past(fall_cnt_reg) == 2'h2 || $past(rd_ft))
    else $error("output register loaded too early");
  chk_std_read_only: assert property (!fwft && $changed(DATA_OUT_O) |-> $past(rd_std))
    else $error("standard mode output changed without a read");
  chk_empty_read_ignored: assert property (r_edge && !sync2_reg.ren_n && !mem_some && !out_valid_reg
                                           |=> $stable(DATA_OUT_O) && $stable(rptr_reg))
    else $error("read taken from an empty buffer");
  chk_write_counts: assert property (wr_ok && !pop |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("accepted write did not add a word");
  chk_full_blocks: assert property (total == capacity |-> !wr_ok)
    else $error("write accepted while full");
  chk_empty_two_stage: assert property (s_read_step ##0 !fwft
                                        |=> EMPTY_FLAG_O == $past(chk_empty_hist_reg[0]))
    else $error("standard empty flag not two stages behind");
  chk_offset_default: assert property ($rose(strap_done_reg) |-> empty_ofs_reg == full_ofs_reg
                                       && empty_ofs_reg == (serial_load_reg ? OFS_SERIAL_DEF : OFS_PARALLEL_DEF))
    else $error("offset default does not match load strap");
  chk_halfway_flag: assert property ($fell(HALF_FULL_FLAG_O) |-> $past(total) == HALF_DEPTH + bias + 16'h0001
                                     || $past(total) > HALF_DEPTH + bias)
    else $error("half-full fell below threshold");
  chk_ready_three_stage: assert property (s_read_step ##0 fwft
      |=> EMPTY_FLAG_O == $past(chk_empty_hist_reg[1]))
    else $error("output-ready flag not three stages behind");
  chk_full_two_stage: assert property (s_write_step
      |=> FULL_FLAG_O == $past(chk_full_hist_reg))
    else $error("full indication not two stages behind");
  chk_almost_empty_level: assert property (s_read_step
      |=> ALMOST_EMPTY_FLAG_O == $past(total >= {1'b0, empty_ofs_reg} + bias + 16'h0001))
    else $error("almost-empty flag does not match the stored count");
  chk_almost_full_level: assert property (s_write_step
      |=> ALMOST_FULL_FLAG_O == $past({1'b0, total} + {2'b00, full_ofs_reg} < {1'b0, capacity}))
    else $error("almost-full flag does not match the stored count");
  chk_half_full_level: assert property (strap_done_reg
      |=> HALF_FULL_FLAG_O == $past(total < HALF_DEPTH + bias + 16'h0001))
    else $error("half-full flag does not match the stored count");
  chk_empty_ofs_write: assert property (apb_commit && sel_eofs && strap_done_reg
      |=> empty_ofs_reg == $past(PWDATA_I[OFS_W-1:0]))
    else $error("empty offset write did not land");
  chk_full_ofs_write: assert property (apb_commit && sel_fofs && strap_done_reg
      |=> full_ofs_reg == $past(PWDATA_I[OFS_W-1:0]))
    else $error("full offset write did not land");
  chk_straps_held: assert property (strap_done_reg |=> $stable(mode_reg) && $stable(serial_load_reg))
    else $error("strap choice changed after it was latched");
  chk_write_after_strap: assert property (!strap_done_reg |-> !wr_ok)
    else $error("write accepted before the straps were latched");
  chk_ft_output_moves: assert property (fwft && $changed(DATA_OUT_O) |-> $past(load_ft))
    else $error("fall-through output changed without a load");

endmodule

`default_nettype wire

// ===== sim/dcf_link_model.sv
// Partner on the link side: write-side and read-side logic driving the pins.
// Assumes a 10 MHz clk_i; one link period is eight clk_i cycles (800 ns).
`timescale 1ns/1ps
`default_nettype none

module dcf_link_model
  import dcf_pkg::*;
(
  input  wire logic              clk_i,    // System clock.
  output logic                   wclk_o,   // Write link clock.
  output logic                   wen_n_o,  // Write enable, low active.
  output logic      [DATA_W-1:0] data_o,   // Write data.
  output logic                   rclk_o,   // Read link clock.
  output logic                   ren_n_o   // Read enable, low active.
);
  logic [DATA_W-1:0] last_d;

  initial begin
    wclk_o  = 1'b0;
    rclk_o  = 1'b0;
    wen_n_o = 1'b1;
    ren_n_o = 1'b1;
    last_d  = '0;
    data_o  = '1;
  end

  // One link period with both clocks pulsed. Enables and data are held across the
  // rising link edge and the synchroniser delay, since the block samples the pins.
  task automatic cyc(input logic w, input logic r, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wen_n_o <= ~w;
    ren_n_o <= ~r;
    data_o  <= w ? d : ~last_d;
    if (w) last_d = d;
    repeat (3) @(posedge clk_i);
    wclk_o <= 1'b1;
    rclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    wclk_o  <= 1'b0;
    rclk_o  <= 1'b0;
    wen_n_o <= 1'b1;
    ren_n_o <= 1'b1;
    // A released bus never shows the last word, so a stale capture cannot pass.
    data_o  <= ~last_d;
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench: a queue model of the buffer is compared with the flags and data.
// Assumes dcf_fifo and dcf_link_model; full depth is out of reach in the run budget.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import dcf_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic              clk, rst, psel, penable, pwrite, mode, ld, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, wclk, wen_n, rclk, ren_n, ef, ff, hf, ae, af;
  logic [DATA_W-1:0] din, dout, last_out;
  logic [DATA_W-1:0] q[$];
  int                fails, n_tests, cyc_cnt, n, m, fw;

  dcf_fifo u_dcf_fifo (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .WCLK_I(wclk), .WEN_N_I(wen_n),
    .DATA_IN_BUS_I(din), .RCLK_I(rclk), .REN_N_I(ren_n), .MODE_SI_I(mode),
    .OFFSET_LOAD_I(ld), .DATA_OUT_O(dout), .EMPTY_FLAG_O(ef), .FULL_FLAG_O(ff),
    .HALF_FULL_FLAG_O(hf), .ALMOST_EMPTY_FLAG_O(ae), .ALMOST_FULL_FLAG_O(af));

  dcf_link_model u_dcf_link_model (.clk_i(clk), .wclk_o(wclk), .wen_n_o(wen_n),
    .data_o(din), .rclk_o(rclk), .ren_n_o(ren_n));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input int f);
    @(posedge clk);
    rst  <= 1'b1;
    mode <= f[0];
    ld   <= f[0];
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    fw = f;
    n = f ? 1023 : 127;
    m = n;
    q.delete();
    last_out = '0;
  endtask

  task automatic check_state;
    chk({31'h0, ef}, 32'(fw ? q.size() == 0 : q.size() != 0));
    chk({31'h0, ae}, 32'(q.size() >= n + 1 + fw));
    chk({31'h0, hf}, 32'(q.size() < 16385 + fw));
    chk({31'h0, af}, 32'(q.size() < 32768 + fw - m));
    chk({31'h0, ff}, 32'(fw ? q.size() > 32768 : q.size() < 32768));
    if (fw != 0 && q.size() > 0) chk({14'h0, dout}, {14'h0, q[0]});
    else if (fw == 0) chk({14'h0, dout}, {14'h0, last_out});
  endtask

  // One link operation, then idle link periods so every flag pipeline settles.
  task automatic op(input logic w, input logic r);
    logic [DATA_W-1:0] d;
    d = DATA_W'($urandom);
    u_dcf_link_model.cyc(w, r, d);
    if (r && q.size() > 0) begin
      if (fw != 0) void'(q.pop_front());
      else last_out = q.pop_front();
    end
    if (w && q.size() < 32768 + fw) q.push_back(d);
    repeat (7) u_dcf_link_model.cyc(1'b0, 1'b0, '0);
    check_state();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, mode, ld} = '0;
    paddr = '0;
    pwdata = '0;
    {fails, n_tests, cyc_cnt} = '0;
    rd = $urandom(32'h475f43e9);
    for (int f = 0; f < 2; f++) begin
      do_reset(f);
      check_state();
      apb(1'b0, ADDR_STATUS, '0);
      chk({29'h0, rd[7:5]}, {29'h0, 1'b1, f[0], f[0]});
      apb(1'b0, ADDR_EMPTY_OFS, '0);
      chk(rd, 32'(n));
      apb(1'b0, ADDR_FULL_OFS, '0);
      chk(rd, 32'(m));
      apb(1'b0, 8'h10, '0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, ADDR_EMPTY_OFS, 32'h2);
      apb(1'b1, ADDR_FULL_OFS, 32'h7FFA);
      n = 2;
      m = 32'h7FFA;
      apb(1'b0, ADDR_FULL_OFS, '0);
      chk(rd, 32'h7FFA);
      op(1'b0, 1'b1);
      repeat (7) op(1'b1, 1'b0);
      op(1'b1, 1'b1);
      apb(1'b0, ADDR_LEVEL, '0);
      chk(rd, 32'(q.size()));
      repeat (9) op(1'b0, 1'b1);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
